// ---- common/mtpc_params.svh ----
`ifndef MTPC_PARAMS_SVH
`define MTPC_PARAMS_SVH
// ==========================================
// Command codes
`define MTPC_CMD_READ 8'h00
`define MTPC_CMD_ERASE 8'h20
`define MTPC_CMD_ERASE_CHECK 8'hA0
`define MTPC_CMD_PROGRAM 8'h40
`define MTPC_CMD_PROGRAM_CHECK 8'hC0
`define MTPC_CMD_RESET 8'hFF
// ==========================================
// Times in their own units, clock in MHz
`define MTPC_CLK_MHZ 250
`define MTPC_RECOVERY_US 6
`define MTPC_PROGRAM_US 10
`define MTPC_ERASE_MS 100
// Least times round up; these are exact multiples of 4 ns
`define MTPC_RECOVERY_CYC (`MTPC_RECOVERY_US * `MTPC_CLK_MHZ)
`define MTPC_PROGRAM_CYC (`MTPC_PROGRAM_US * `MTPC_CLK_MHZ)
`define MTPC_ERASE_CYC (`MTPC_ERASE_MS * 1000 * `MTPC_CLK_MHZ)
// Strobe phase counts, each one less than the phase length in cycles: setup, low pulse, hold
`define MTPC_SETUP_CYC 4'h2
`define MTPC_PULSE_CYC 4'hF
`define MTPC_HOLD_CYC 4'h4
`define MTPC_READ_CYC 4'hF
`endif

// ---- common/mtpc_pkg.sv ----
package mtpc_pkg;
  typedef enum logic [2:0] {
    MTPC_OP_READ = 3'b000,
    MTPC_OP_ERASE = 3'b001,
    MTPC_OP_ERASE_CHECK = 3'b010,
    MTPC_OP_PROGRAM = 3'b011,
    MTPC_OP_PROGRAM_CHECK = 3'b100,
    MTPC_OP_RESET = 3'b101
  } mtpc_op_t;
  typedef enum logic [2:0] {
    MTPC_ST_IDLE = 3'b000,
    MTPC_ST_SETUP = 3'b001,
    MTPC_ST_PULSE = 3'b010,
    MTPC_ST_HOLD = 3'b011,
    MTPC_ST_WAIT = 3'b100,
    MTPC_ST_READ = 3'b101
  } mtpc_state_t;
endpackage : mtpc_pkg

// ---- core/mtpc_ctrl.sv ----
// Functional notes
// - Read mode is one write of 00h; device powers up in read mode.
// - Bulk erase is 20h written twice back to back, address ignored.
// - Erase check writes A0h with location, next read returns that byte.
// - Program is 40h then a write carrying location and byte.
// - Program check writes C0h, next read returns byte at held location.
// - Wait at least 10 us after program write before the next strobe.
// - Wait at least 100 ms after erase start before erase check strobe.
// - Wait at least 6 us after strobe rising edge before output enable.
`timescale 1ns/100ps
`default_nettype none
`include "mtpc_params.svh"
module mtpc_ctrl
  import mtpc_pkg::*;
#(
  parameter int ADDR_W = 17,
  parameter int RECOVERY_CYC = `MTPC_RECOVERY_CYC,
  parameter int PROGRAM_CYC = `MTPC_PROGRAM_CYC,
  parameter int ERASE_CYC = `MTPC_ERASE_CYC
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [2:0] req_op,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [7:0] req_data,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic [ADDR_W-1:0] mem_addr,
  output logic [7:0] mem_dq_out,
  output logic mem_dq_oe,
  input wire logic [7:0] mem_dq_in,
  output logic mem_chip_n,
  output logic mem_out_en_n,
  output logic mem_write_n
);
  // ==========================================
  // Pin input synchroniser
  logic [7:0] dq_meta;
  logic [7:0] dq_sync;
  always_ff @(posedge ref_clk) begin
    dq_meta <= mem_dq_in;
    dq_sync <= dq_meta;
  end

  // ==========================================
  // Sequencer state
  mtpc_state_t state;
  mtpc_state_t next_state;
  mtpc_op_t op;
  logic [3:0] phase_cnt;
  logic [31:0] wait_cnt;
  logic [31:0] recov_cnt;
  logic second;
  logic [7:0] cmd_byte;
  logic [7:0] dat_byte;
  logic [ADDR_W-1:0] addr_hold;

  // Command byte for each op; 2nd write of program carries the data byte
  function automatic logic [7:0] mtpc_code(input mtpc_op_t o);
    case (o)
      MTPC_OP_READ: mtpc_code = `MTPC_CMD_READ;
      MTPC_OP_ERASE: mtpc_code = `MTPC_CMD_ERASE;
      MTPC_OP_ERASE_CHECK: mtpc_code = `MTPC_CMD_ERASE_CHECK;
      MTPC_OP_PROGRAM: mtpc_code = `MTPC_CMD_PROGRAM;
      MTPC_OP_PROGRAM_CHECK: mtpc_code = `MTPC_CMD_PROGRAM_CHECK;
      default: mtpc_code = `MTPC_CMD_RESET;
    endcase
  endfunction : mtpc_code

  // Which ops write a second strobe, which end in a read
  // Read mode write is followed by one array read, else the mode could never be used
  wire two_writes = (op == MTPC_OP_ERASE) || (op == MTPC_OP_PROGRAM) || (op == MTPC_OP_RESET);
  wire ends_read = (op == MTPC_OP_READ) || (op == MTPC_OP_ERASE_CHECK) || (op == MTPC_OP_PROGRAM_CHECK);
  wire phase_done = (phase_cnt == 4'h0);
  wire recov_done = (recov_cnt == 32'h0);
  wire wait_done = (wait_cnt == 32'h0);
  wire [2:0] op_bits = req_op;
  // Codes 6 and 7 are dropped, so no undefined command byte reaches the device
  wire op_legal = (op_bits <= 3'h5);
  // Strobe may only open once program or erase minimum time has run out
  assign req_ready = (state == MTPC_ST_IDLE) && wait_done;

  // Next-state decode
  always_comb begin
    next_state = state;
    case (state)
      MTPC_ST_IDLE: if (req_valid && req_ready && op_legal) next_state = MTPC_ST_SETUP;
      MTPC_ST_SETUP: if (phase_done) next_state = MTPC_ST_PULSE;
      MTPC_ST_PULSE: if (phase_done) next_state = MTPC_ST_HOLD;
      MTPC_ST_HOLD: begin
        if (phase_done) begin
          if (two_writes && !second) next_state = MTPC_ST_SETUP;
          else if (ends_read) next_state = MTPC_ST_WAIT;
          else next_state = MTPC_ST_IDLE;
        end
      end
      MTPC_ST_WAIT: if (recov_done) next_state = MTPC_ST_READ;
      MTPC_ST_READ: if (phase_done) next_state = MTPC_ST_IDLE;
      default: next_state = MTPC_ST_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state <= MTPC_ST_IDLE;
      op <= MTPC_OP_READ;
      phase_cnt <= 4'h0;
      second <= 1'b0;
      cmd_byte <= 8'h00;
      dat_byte <= 8'h00;
      addr_hold <= '0;
    end else begin
      state <= next_state;
      if (state == MTPC_ST_IDLE && next_state == MTPC_ST_SETUP) begin
        op <= mtpc_op_t'(req_op);
        cmd_byte <= mtpc_code(mtpc_op_t'(req_op));
        dat_byte <= req_data;
        addr_hold <= req_addr;
        second <= 1'b0;
      end else if (state == MTPC_ST_HOLD && next_state == MTPC_ST_SETUP) begin
        second <= 1'b1;
        // Program's second write carries the byte; others repeat the code
        if (op == MTPC_OP_PROGRAM) cmd_byte <= dat_byte;
      end
      case (next_state)
        MTPC_ST_SETUP: phase_cnt <= (state == MTPC_ST_SETUP) ? phase_cnt - 4'h1 : `MTPC_SETUP_CYC;
        MTPC_ST_PULSE: phase_cnt <= (state == MTPC_ST_PULSE) ? phase_cnt - 4'h1 : `MTPC_PULSE_CYC;
        MTPC_ST_HOLD: phase_cnt <= (state == MTPC_ST_HOLD) ? phase_cnt - 4'h1 : `MTPC_HOLD_CYC;
        MTPC_ST_READ: phase_cnt <= (state == MTPC_ST_READ) ? phase_cnt - 4'h1 : `MTPC_READ_CYC;
        default: phase_cnt <= 4'h0;
      endcase
    end
  end

  // Minimum-time counters; only least times are kept, never a maximum
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wait_cnt <= 32'h0;
      recov_cnt <= 32'h0;
    end else begin
      if (state == MTPC_ST_HOLD && phase_done && second && op == MTPC_OP_PROGRAM)
        wait_cnt <= PROGRAM_CYC[31:0];
      else if (state == MTPC_ST_HOLD && phase_done && second && op == MTPC_OP_ERASE)
        wait_cnt <= ERASE_CYC[31:0];
      else if (!wait_done)
        wait_cnt <= wait_cnt - 32'h1;
      if (state == MTPC_ST_HOLD && phase_done)
        recov_cnt <= RECOVERY_CYC[31:0];
      else if (!recov_done)
        recov_cnt <= recov_cnt - 32'h1;
    end
  end

  // Pin drive; address and data steady across whole strobe
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mem_addr <= '0;
      mem_dq_out <= 8'h00;
      mem_dq_oe <= 1'b0;
      mem_chip_n <= 1'b1;
      mem_out_en_n <= 1'b1;
      mem_write_n <= 1'b1;
    end else begin
      mem_addr <= addr_hold;
      mem_dq_out <= cmd_byte;
      mem_dq_oe <= (next_state == MTPC_ST_SETUP) || (next_state == MTPC_ST_PULSE) || (next_state == MTPC_ST_HOLD);
      mem_chip_n <= (next_state == MTPC_ST_IDLE) || (next_state == MTPC_ST_WAIT);
      mem_write_n <= (next_state != MTPC_ST_PULSE);
      mem_out_en_n <= (next_state != MTPC_ST_READ);
    end
  end

  // Read result is sampled at end of the read window
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
    end else begin
      rsp_valid <= (state == MTPC_ST_READ) && phase_done;
      if (state == MTPC_ST_READ && phase_done) rsp_data <= dq_sync;
    end
  end

  // Cycles since the write strobe was last low, saturating; starts as long ago
  logic [31:0] since_write;
  always_ff @(posedge ref_clk) begin
    if (reset) since_write <= 32'hFFFFFFFF;
    else if (!mem_write_n) since_write <= 32'h0;
    else if (since_write != 32'hFFFFFFFF) since_write <= since_write + 32'h1;
  end

  // ==========================================
  // Checks
  chk_recovery_gap: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(mem_write_n) |-> mem_out_en_n [*8])
    else $error("output enable too soon after write");
  chk_program_wait: assert property (@(posedge ref_clk) disable iff (reset)
    (state == MTPC_ST_HOLD && phase_done && second && op == MTPC_OP_PROGRAM) |=> !req_ready [*8])
    else $error("program wait not kept");
  chk_no_contention: assert property (@(posedge ref_clk) disable iff (reset)
    !(mem_dq_oe && !mem_out_en_n))
    else $error("bus contention");
  chk_addr_stable: assert property (@(posedge ref_clk) disable iff (reset)
    (!mem_write_n && $past(!mem_write_n)) |-> $stable(mem_addr) && $stable(mem_dq_out))
    else $error("address or data moved under strobe");
  chk_strobe_select: assert property (@(posedge ref_clk) disable iff (reset)
    !mem_write_n |-> !mem_chip_n && mem_dq_oe)
    else $error("strobe without select");
  chk_read_answer: assert property (@(posedge ref_clk) disable iff (reset)
    (state == MTPC_ST_READ && phase_done) |=> rsp_valid)
    else $error("read answer missing");
  // Full recovery time is counted, not just a few cycles after the strobe
  chk_read_recovery: assert property (@(posedge ref_clk) disable iff (reset)
    $fell(mem_out_en_n) |-> (since_write >= RECOVERY_CYC[31:0]))
    else $error("read strobe inside write recovery");
endmodule : mtpc_ctrl
`default_nettype wire

// ---- verif/mtpc_dev_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========
// Device on the far side, times in ns
module mtpc_dev_model #(
  parameter real REC_NS = 6000.0,
  parameter real PROG_NS = 10000.0,
  parameter real ERASE_NS = 100.0e6
) (
  input wire logic [16:0] addr,
  input wire logic [7:0] dq,
  input wire logic chip_n,
  input wire logic out_en_n,
  input wire logic write_n,
  output logic [7:0] dq_q,
  output logic viol
);
  logic [7:0] mem [logic [16:0]];
  logic [16:0] la, pl, cl;
  int m = 0; // 0 read, 1 erase armed, 2 program armed, 3 check, 4 reset armed
  realtime t_ok = 0.0;
  realtime t_wh = -1.0e9;
  function automatic logic [7:0] rd(input logic [16:0] a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction : rd
  initial viol = 1'b0;
  // A strobe that lands inside a running operation would cut it short
  always @(negedge write_n) if (!chip_n) begin
    la = addr;
    if ($realtime < t_ok) viol = 1'b1;
  end
  // Command decode on the rising strobe
  always @(posedge write_n) if (!chip_n) begin
    t_wh = $realtime;
    t_ok = 0.0;
    if (m == 2) begin
      mem[la] = rd(la) & dq;
      pl = la;
      t_ok = $realtime + PROG_NS;
      m = 0;
    end else if (m == 1 && dq == 8'h20) begin
      mem.delete();
      t_ok = $realtime + ERASE_NS;
      m = 0;
    end else if (m == 4 && dq == 8'hFF) m = 0;
    else case (dq)
      8'h00: m = 0;
      8'h20: m = 1;
      8'h40: m = 2;
      8'hA0: begin cl = la; m = 3; end
      8'hC0: begin cl = pl; m = 3; end
      8'hFF: m = 4;
      default: ;
    endcase
  end
  always @(negedge out_en_n) if ($realtime - t_wh < REC_NS) viol = 1'b1;
  // Released bus shows the inverse so that stale data never passes
  always @(chip_n or out_en_n or addr or write_n) begin
    dq_q = (m == 3) ? rd(cl) : rd(addr);
    if (chip_n || out_en_n) dq_q = ~dq_q;
  end
endmodule : mtpc_dev_model
`default_nettype wire

// ---- verif/mtpc_ctrl_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module mtpc_ctrl_tb_top;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic req_valid = 1'b0;
  logic [2:0] req_op = 3'h0;
  logic [16:0] req_addr = 17'h00000;
  logic [7:0] req_data = 8'h00;
  wire req_ready, rsp_valid, dq_oe, chip_n, oe_n, wr_n, viol;
  wire [7:0] rsp_data, dq_out, dev_q, dq_bus;
  wire [16:0] addr;
  int fail_count = 0;
  int n_checks = 0;
  int cycles = 0;
  assign dq_bus = dq_oe ? dq_out : dev_q;
  // Erase wait shortened; the model's erase time follows it
  mtpc_ctrl #(.ERASE_CYC(50)) dut (.ref_clk(ref_clk), .reset(reset), .req_valid(req_valid),
    .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr), .req_data(req_data),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data), .mem_addr(addr), .mem_dq_out(dq_out),
    .mem_dq_oe(dq_oe), .mem_dq_in(dq_bus), .mem_chip_n(chip_n), .mem_out_en_n(oe_n),
    .mem_write_n(wr_n));
  mtpc_dev_model #(.ERASE_NS(200.0)) dev (.addr(addr), .dq(dq_bus), .chip_n(chip_n),
    .out_en_n(oe_n), .write_n(wr_n), .dq_q(dev_q), .viol(viol));
  initial forever #2 ref_clk = ~ref_clk;
  // ==========
  // Hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 100000) begin
      fail_count++;
      results();
    end
  end
  task check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // One request; read kinds wait for the answer and compare it
  task automatic op(input logic [2:0] o, input logic [16:0] a, input logic [7:0] d, input logic [7:0] e);
    int n;
    n = 0;
    @(negedge ref_clk);
    while (req_ready !== 1'b1 && n < 40000) begin @(negedge ref_clk); n++; end
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_op <= o;
    req_addr <= a;
    req_data <= d;
    @(posedge ref_clk);
    req_valid <= 1'b0;
    n = 0;
    if (o == 3'h0 || o == 3'h2 || o == 3'h4) begin
      while (rsp_valid !== 1'b1 && n < 4000) begin @(negedge ref_clk); n++; end
      check(rsp_valid === 1'b1 ? rsp_data : 8'hXX, e);
    end
  endtask : op
  // ==========
  // Scenarios
  task t_fresh;
    op(3'h2, 17'h1FFFF, 8'h00, 8'hFF);
  endtask : t_fresh
  task t_program;
    op(3'h3, 17'h01234, 8'hA5, 8'h00);
    op(3'h4, 17'h00000, 8'h00, 8'hA5);
    op(3'h0, 17'h01234, 8'h00, 8'hA5);
  endtask : t_program
  task t_clear_bits;
    op(3'h3, 17'h01234, 8'h0F, 8'h00);
    op(3'h4, 17'h1FFFF, 8'h00, 8'h05);
  endtask : t_clear_bits
  task t_reset_junk;
    op(3'h5, 17'h00000, 8'h00, 8'h00);
    op(3'h6, 17'h01234, 8'h00, 8'h00);
    op(3'h7, 17'h01234, 8'h00, 8'h00);
    op(3'h0, 17'h01234, 8'h00, 8'h05);
  endtask : t_reset_junk
  task t_erase;
    op(3'h1, 17'h00000, 8'h00, 8'h00);
    op(3'h2, 17'h01234, 8'h00, 8'hFF);
    op(3'h0, 17'h01234, 8'h00, 8'hFF);
  endtask : t_erase
  task results;
    $display("checks=%0d mismatches=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : results
  initial begin
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    t_fresh();
    t_program();
    t_clear_bits();
    t_reset_junk();
    t_erase();
    check({7'h00, viol}, 8'h00);
    results();
  end
endmodule : mtpc_ctrl_tb_top
`default_nettype wire
